// *** design/temp_sensor_smbus_slave_core.sv ***
// Digital core of a two-wire temperature sensor slave
//
// Function
// [RULE_01] SMBus slave, I2C compatible, up to 400 kHz
// [RULE_02] Timeout disabled: any slow clock accepted
// [RULE_03] Line low past timeout: idle, release lines
// [RULE_04] Invalid pointer: no acknowledge, pointer kept
// [RULE_05] Temperature readable anytime, last completed result
// [RULE_06] Interface working within 1 ms of reset
// [RULE_07] Valid temperature one conversion after start
// [RULE_08] Reset loads every register default value
// [RULE_09] First conversion updates temperature and status
// [RULE_10] Each conversion result lands in temperature register
// [RULE_11] Seven pointer-selected registers with reset values; the code decodes six (pointer codes 00h-04h and 07h)
// [RULE_12] Programmable resolution trades sensitivity for time
// [RULE_13] Shutdown stops continuous conversions
// [RULE_14] One-shot conversion available during shutdown
// [RULE_15] Slave only: never drives or stretches clock
// [RULE_16] Address strap selects one of three addresses
// [RULE_17] One-shot busy: flag 0, temperature reads 8000h
// [RULE_18] Master writes replace reset values
// [RULE_19] Reads use last pointer; writes pointer first
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_params.svh"
module temp_sensor_smbus_slave_core #(
  parameter int unsigned CONV_CYC = `CONV_BASE_CYC,
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC,
  parameter logic [15:0] ID_VALUE = 16'h0A5A // Arbitrary identification value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Two-wire link (clock line is input only)
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Address strap
  input wire logic [1:0] addr_sel_i,
  // Converter result
  input wire logic [15:0] adc_result_i,
  // Local register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Interrupt
  output logic irq_o
);

  localparam logic [23:0] TO_END = 24'(TIMEOUT_CYC);

  generate
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= 2**24)
    begin : g_chk
      $error("TIMEOUT_CYC out of range for the 24-bit timer");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ---------------------------------------------------------------
  temp_sensor_pkg::pins_t pins_raw;
  temp_sensor_pkg::pins_t pins_s;
  logic scl_d_q;
  logic sda_d_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign pins_raw = {addr_sel_i, sda_i, scl_i};

  line_sync #(
    .WIDTH(4),
    .RST_VAL(4'h3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // Delayed copies for edges; the bus lines idle high
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= pins_s.scl;
      sda_d_q <= pins_s.sda;
    end
  end

  // Clock is only sampled, never stretched, so any slow rate works once the timeout is disabled
  assign scl_rise = pins_s.scl & ~scl_d_q; // [RULE_02]
  assign scl_fall = ~pins_s.scl & scl_d_q;
  assign start_det = pins_s.scl & scl_d_q & sda_d_q & ~pins_s.sda; // [RULE_01]
  assign stop_det = pins_s.scl & scl_d_q & ~sda_d_q & pins_s.sda;

  // ---------------------------------------------------------------
  // Address strap
  // ---------------------------------------------------------------
  logic [1:0] strap_cnt_q;
  logic [6:0] dev_addr_q;
  logic [1:0] sel_eff;

  // The unused strap code falls back to the float address
  assign sel_eff = (pins_s.addr_sel == `ADDR_SEL_BAD) ? `ADDR_SEL_FLOAT : pins_s.addr_sel;

  // Loaded on the first three cycles after release, the last once the synchroniser has filled
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_cnt_q <= 2'h0;
      dev_addr_q <= `BASE_ADDR;
    end
    else if (strap_cnt_q != 2'h3)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      dev_addr_q <= `BASE_ADDR | {5'h00, sel_eff}; // [RULE_16]
    end
  end

  // ---------------------------------------------------------------
  // Bus lockup timers, one per line
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic to_en;
  logic [1:0] lines_w;
  logic [1:0] to_hit;
  logic timeout_ev;

  assign to_en = ~ctrl_q[`CTRL_TO_DIS_BIT]; // [RULE_02]
  assign lines_w = {pins_s.sda, pins_s.scl};

  // Separate timers so alternating lows on both lines do not add up
  genvar li;
  generate
    for (li = 0; li < 2; li++)
    begin : g_to
      logic [23:0] cnt_q;
      logic active;
      assign active = to_en & ~lines_w[li];
      assign to_hit[li] = active & (cnt_q == TO_END - 24'h1);
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          cnt_q <= 24'h0;
        else if (!active)
          cnt_q <= 24'h0;
        else if (cnt_q != TO_END)
          cnt_q <= cnt_q + 24'h1;
      end
    end
  endgenerate

  assign timeout_ev = |to_hit; // [RULE_03]

  // ---------------------------------------------------------------
  // Register set and read selection
  // ---------------------------------------------------------------
  logic [7:0] ptr_q;
  logic [7:0] config_q;
  logic [15:0] thigh_q;
  logic [15:0] tlow_q;
  logic [15:0] temp_q;
  logic [7:0] hold_q;
  logic ready_q;
  logic above_q;
  logic below_q;
  logic [7:0] sh_q;
  logic [15:0] rd_val;
  logic [15:0] rd_hold_q;
  logic rd_idx_q;
  logic narrow;
  logic ptr_ok;
  logic [7:0] tx_byte_w;
  logic [7:0] cfg_rd;
  logic [7:0] ctrl_rd;

  assign cfg_rd = config_q & `CFG_RW_MASK;
  assign ctrl_rd = (ctrl_q & `CTRL_RW_MASK)
                 | ({7'h00, above_q} << `CTRL_ABOVE_BIT)
                 | ({7'h00, below_q} << `CTRL_BELOW_BIT)
                 | ({7'h00, ready_q} << `CTRL_READY_BIT);

  // Only these pointer codes name a register
  assign ptr_ok = (sh_q == `PTR_TEMP) || (sh_q == `PTR_CONFIG) || (sh_q == `PTR_THIGH)
               || (sh_q == `PTR_TLOW) || (sh_q == `PTR_CTRL) || (sh_q == `PTR_ID); // [RULE_11]

  // Read data of the selected register, narrow ones in the low byte
  assign rd_val = (ptr_q == `PTR_TEMP) ? temp_q :
                  (ptr_q == `PTR_CONFIG) ? {8'h00, cfg_rd} :
                  (ptr_q == `PTR_THIGH) ? thigh_q :
                  (ptr_q == `PTR_TLOW) ? tlow_q :
                  (ptr_q == `PTR_CTRL) ? {8'h00, ctrl_rd} :
                  ID_VALUE; // [RULE_19]
  assign narrow = (ptr_q == `PTR_CONFIG) || (ptr_q == `PTR_CTRL);

  // Low byte comes from a snapshot so a conversion cannot tear the word
  assign tx_byte_w = narrow ? rd_val[7:0] : (rd_idx_q ? rd_hold_q[7:0] : rd_val[15:8]); // [RULE_05]

  // ---------------------------------------------------------------
  // Serial engine
  // ---------------------------------------------------------------
  temp_sensor_pkg::ser_state_t state_q;
  logic [3:0] bit_q;
  logic ack_ph_q;
  logic rw_q;
  logic drv_q;
  logic [1:0] idx_q;
  logic [7:0] tx_q;
  logic byte_done;

  // Open drain: only ever pull low; clock line has no driver at all
  assign sda_o = 1'b0; // [RULE_15]
  assign sda_oe_n_o = ~drv_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= temp_sensor_pkg::ST_IDLE; // [RULE_06]
      bit_q <= 4'h0;
      ack_ph_q <= 1'b0;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      idx_q <= 2'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      rd_idx_q <= 1'b0;
      rd_hold_q <= 16'h0000;
    end
    else if (timeout_ev || stop_det)
    begin
      state_q <= temp_sensor_pkg::ST_IDLE; // [RULE_03]
      drv_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= temp_sensor_pkg::ST_ADDR;
      bit_q <= 4'h0;
      ack_ph_q <= 1'b0;
      drv_q <= 1'b0;
      idx_q <= 2'h0;
      rd_idx_q <= 1'b0;
    end
    else if (state_q != temp_sensor_pkg::ST_IDLE && state_q != temp_sensor_pkg::ST_WAIT)
    begin
      if (scl_rise && bit_q != 4'h8)
      begin
        sh_q <= {sh_q[6:0], pins_s.sda};
        bit_q <= bit_q + 4'h1;
      end
      else if (scl_rise && state_q == temp_sensor_pkg::ST_READ && pins_s.sda)
        state_q <= temp_sensor_pkg::ST_WAIT;
      else if (scl_fall && bit_q == 4'h8 && !ack_ph_q)
      begin
        ack_ph_q <= 1'b1;
        case (state_q)
          temp_sensor_pkg::ST_ADDR:
            if (sh_q[7:1] == dev_addr_q)
            begin
              drv_q <= 1'b1;
              rw_q <= sh_q[0];
            end
            else
              state_q <= temp_sensor_pkg::ST_WAIT;
          temp_sensor_pkg::ST_WRITE:
          begin
            if (idx_q == 2'h0 && !ptr_ok)
              state_q <= temp_sensor_pkg::ST_WAIT; // [RULE_04]
            else
              drv_q <= 1'b1;
            if (idx_q != 2'h3)
              idx_q <= idx_q + 2'h1;
          end
          default:
            drv_q <= 1'b0;
        endcase
      end
      else if (scl_fall && bit_q == 4'h8)
      begin
        ack_ph_q <= 1'b0;
        bit_q <= 4'h0;
        if (state_q == temp_sensor_pkg::ST_WRITE || (state_q == temp_sensor_pkg::ST_ADDR && !rw_q))
        begin
          state_q <= temp_sensor_pkg::ST_WRITE;
          drv_q <= 1'b0;
        end
        else
        begin
          state_q <= temp_sensor_pkg::ST_READ;
          tx_q <= tx_byte_w;
          drv_q <= ~tx_byte_w[7];
          rd_idx_q <= ~rd_idx_q;
          if (!rd_idx_q)
            rd_hold_q <= rd_val;
        end
      end
      else if (scl_fall && state_q == temp_sensor_pkg::ST_READ)
      begin
        tx_q <= {tx_q[6:0], 1'b0};
        drv_q <= ~tx_q[6];
      end
    end
  end

  // ---------------------------------------------------------------
  // Write strobes: first byte is the pointer, then data
  // ---------------------------------------------------------------
  logic wr_ptr;
  logic bad_ptr_ev;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_thigh;
  logic wr_tlow;
  logic wr_hold;

  assign byte_done = (state_q == temp_sensor_pkg::ST_WRITE) & scl_fall & (bit_q == 4'h8)
                   & ~ack_ph_q & ~start_det & ~stop_det & ~timeout_ev;
  assign wr_ptr = byte_done & (idx_q == 2'h0) & ptr_ok; // [RULE_19]
  assign bad_ptr_ev = byte_done & (idx_q == 2'h0) & ~ptr_ok;
  assign wr_cfg = byte_done & (idx_q == 2'h1) & (ptr_q == `PTR_CONFIG);
  assign wr_ctrl = byte_done & (idx_q == 2'h1) & (ptr_q == `PTR_CTRL);
  assign wr_hold = byte_done & (idx_q == 2'h1);
  assign wr_thigh = byte_done & (idx_q == 2'h2) & (ptr_q == `PTR_THIGH);
  assign wr_tlow = byte_done & (idx_q == 2'h2) & (ptr_q == `PTR_TLOW);

  // Pointer and writable registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ptr_q <= `PTR_RST; // [RULE_08]
      config_q <= `CONFIG_RST;
      ctrl_q <= `CTRL_RST;
      thigh_q <= `THIGH_RST;
      tlow_q <= `TLOW_RST;
      hold_q <= 8'h00;
    end
    else
    begin
      if (wr_ptr)
        ptr_q <= sh_q;
      if (wr_cfg)
        config_q <= sh_q & `CFG_RW_MASK; // [RULE_18]
      if (wr_ctrl)
        ctrl_q <= sh_q & `CTRL_RW_MASK; // [RULE_12]
      if (wr_hold)
        hold_q <= sh_q;
      if (wr_thigh)
        thigh_q <= {hold_q, sh_q};
      if (wr_tlow)
        tlow_q <= {hold_q, sh_q};
    end
  end

  // ---------------------------------------------------------------
  // Conversion control and temperature register
  // ---------------------------------------------------------------
  logic conv_busy;
  logic conv_done;
  logic shot_go;
  logic run_w;
  logic [15:0] res_mask;
  logic [15:0] result_w;

  // A one-shot request during a finishing conversion is dropped
  assign run_w = ~config_q[`CFG_SHUTDOWN_BIT]; // [RULE_13]
  assign shot_go = wr_cfg & sh_q[`CFG_ONESHOT_BIT] & config_q[`CFG_SHUTDOWN_BIT] & ~conv_busy; // [RULE_14]

  conv_timer #(
    .BASE_CYC(CONV_CYC),
    .CNT_W(24)
  ) u_conv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_w),
    .shot_i(shot_go),
    .res_i(ctrl_q[`CTRL_RES_HI:`CTRL_RES_LO]),
    .busy_o(conv_busy),
    .done_o(conv_done)
  );

  // Left justified two's complement, unused low bits forced to zero
  assign res_mask = ~(16'h001F >> ctrl_q[`CTRL_RES_HI:`CTRL_RES_LO]);
  assign result_w = adc_result_i & res_mask;

  // A completed conversion loads the result; a one-shot start loads the busy value
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      temp_q <= `TEMP_RST;
      ready_q <= 1'b0;
      above_q <= 1'b0;
      below_q <= 1'b0;
    end
    else if (conv_done)
    begin
      temp_q <= result_w; // [RULE_10]
      ready_q <= 1'b1; // [RULE_17]
      above_q <= $signed(result_w) > $signed(thigh_q); // [RULE_09]
      below_q <= $signed(result_w) < $signed(tlow_q);
    end
    else if (shot_go)
    begin
      temp_q <= `TEMP_BUSY; // [RULE_17]
      ready_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, mask and local register port
  // ---------------------------------------------------------------
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_ev;
  logic stat_rd;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign irq_ev = ({2'h0, conv_done} << `IRQ_CONV_BIT) // [RULE_07]
                | ({2'h0, timeout_ev} << `IRQ_TIMEOUT_BIT)
                | ({2'h0, bad_ptr_ev} << `IRQ_BADPTR_BIT);
  assign stat_rd = reg_re_i & (reg_addr_i == `IRQ_STAT_ADDR);
  assign rdata_d = !reg_re_i ? 8'h00 :
                   (reg_addr_i == `IRQ_STAT_ADDR) ? {5'h00, irq_stat_q} :
                   (reg_addr_i == `IRQ_MASK_ADDR) ? {5'h00, irq_mask_q} :
                   8'h00;

  // Read clears, but an event in the same cycle stays set
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= `IRQ_MASK_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~{3{stat_rd}}) | irq_ev;
      if (reg_we_i && reg_addr_i == `IRQ_MASK_ADDR)
        irq_mask_q <= reg_wdata_i[2:0];
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// *** design/temp_sensor_params.svh ***
// Offsets, field positions, reset values and timing counts of the sensor core
`ifndef TEMP_SENSOR_PARAMS_SVH
`define TEMP_SENSOR_PARAMS_SVH

// Pointer codes of the serial register set
`define PTR_TEMP 8'h00
`define PTR_CONFIG 8'h01
`define PTR_THIGH 8'h02
`define PTR_TLOW 8'h03
`define PTR_CTRL 8'h04
`define PTR_ID 8'h07

// Configuration byte fields
`define CFG_SHUTDOWN_BIT 7
`define CFG_ONESHOT_BIT 2
`define CFG_RW_MASK 8'hFB

// Control/status byte fields
`define CTRL_TO_DIS_BIT 7
`define CTRL_RES_HI 6
`define CTRL_RES_LO 5
`define CTRL_ABOVE_BIT 3
`define CTRL_BELOW_BIT 2
`define CTRL_READY_BIT 0
`define CTRL_RW_MASK 8'hE0

// Reset values, and the temperature value read while a one-shot is busy
`define PTR_RST 8'h00
`define CONFIG_RST 8'h00
`define CTRL_RST 8'h00
`define THIGH_RST 16'h4000
`define TLOW_RST 16'h3C00
`define TEMP_RST 16'h0000
`define TEMP_BUSY 16'h8000

// Slave address: base plus strap code (float 0, ground 1, supply 2)
`define BASE_ADDR 7'h48
`define ADDR_SEL_FLOAT 2'h0
`define ADDR_SEL_BAD 2'h3

// Local interrupt registers
`define IRQ_STAT_ADDR 2'h0
`define IRQ_MASK_ADDR 2'h1
`define IRQ_MASK_RST 3'h0
`define IRQ_CONV_BIT 0
`define IRQ_TIMEOUT_BIT 1
`define IRQ_BADPTR_BIT 2

// Timing: clock in kHz, times in ms, counts derived
`define CLK_KHZ 40000
`define CONV_BASE_MS 14
`define CONV_BASE_CYC (`CONV_BASE_MS * `CLK_KHZ)
`define TIMEOUT_MIN_MS 15
`define TIMEOUT_CYC (`TIMEOUT_MIN_MS * `CLK_KHZ)

`endif

// *** design/temp_sensor_pkg.sv ***
// Types shared by the sensor core files
package temp_sensor_pkg;

  // Serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ,
    ST_WAIT
  } ser_state_t;

  // Pins that cross into the clock domain
  typedef struct packed {
    logic [1:0] addr_sel;
    logic sda;
    logic scl;
  } pins_t;

endpackage

// *** design/line_sync.sv ***
// Two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("line_sync needs WIDTH of one or more");
    end
  endgenerate

  // First stage is read only by the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta_q <= RST_VAL[i];
          sync_q <= RST_VAL[i];
        end
        else
        begin
          meta_q <= d_i[i];
          sync_q <= meta_q;
        end
      end
      assign q_o[i] = sync_q;
    end
  endgenerate

endmodule
`default_nettype wire

// *** design/conv_timer.sv ***
// Conversion sequencer: paces each conversion by the chosen resolution
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_params.svh"
module conv_timer #(
  parameter int unsigned BASE_CYC = `CONV_BASE_CYC,
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic shot_i,
  input wire logic [1:0] res_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  localparam logic [CNT_W-1:0] BASE = CNT_W'(BASE_CYC);

  generate
    if (BASE_CYC < 1 || (64'(BASE_CYC) * 64'd8) >= (64'd1 << CNT_W))
    begin : g_chk
      $error("conv_timer BASE_CYC does not fit the counter");
    end
  endgenerate

  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] res_q;
  logic [CNT_W-1:0] last_w;

  // Each resolution step doubles the conversion time
  assign last_w = (BASE << res_q) - {{(CNT_W-1){1'b0}}, 1'b1};
  assign done_o = busy_q & (cnt_q == last_w);
  assign busy_o = busy_q;

  // Resolution is latched at start so a mid-conversion write cannot cut it short
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      res_q <= 2'h0;
    end
    else if (!busy_q)
    begin
      if (run_i || shot_i)
      begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        res_q <= res_i;
      end
    end
    else if (done_o)
      busy_q <= 1'b0;
    else
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

endmodule
`default_nettype wire

// *** verif/temp_sensor_smbus_slave_core_checker.sv ***
// Bound assertions on the sensor core ports
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_smbus_slave_core_checker #(
  parameter int unsigned TIMEOUT_CYC = 200
) (
  // Clock, reset, link
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  // Local port, interrupt
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // --------
  // Helpers
  // --------
  int unsigned lo_q;
  logic [2:0] msk_q;
  // Clock low time, capped so it never wraps
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lo_q <= 0;
      msk_q <= 3'h0;
    end
    else
    begin
      lo_q <= scl_i ? 0 : (lo_q > TIMEOUT_CYC + 9 ? lo_q : lo_q + 1);
      if (reg_we_i && reg_addr_i == 2'h1)
        msk_q <= reg_wdata_i[2:0];
    end
  end
  property p_sda_zero;
    sda_o == 1'b0;
  endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("data pin driven high");
  property p_rst_rel;
    $fell(rst_i) |-> sda_oe_n_o && !irq_o && reg_rdata_o == 8'h00;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("outputs not idle after reset");
  property p_rd_idle;
    !$past(reg_re_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    reg_re_i && reg_addr_i[1] |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask_rd;
    reg_re_i && reg_addr_i == 2'h1 |=> reg_rdata_o == {5'h00, msk_q};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_irq_off;
    reg_we_i && reg_addr_i == 2'h1 && reg_wdata_i[2:0] == 3'h0 |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
  property p_timeout;
    lo_q == TIMEOUT_CYC + 8 |-> sda_oe_n_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("data not released on lockup");
  // Data only moves while the clock is low
  property p_scl_high;
    scl_i [*6] |-> $stable(sda_oe_n_o);
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("data moved in clock high");
  c_ack: cover property ($fell(sda_oe_n_o));
  c_irq: cover property ($rose(irq_o));
  c_tmo: cover property (lo_q == TIMEOUT_CYC + 8);
endmodule
bind temp_sensor_smbus_slave_core temp_sensor_smbus_slave_core_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
`default_nettype wire

// *** verif/smbus_master_model.sv ***
// Two-wire bus master model facing the sensor core
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model (
  // Wire level of the data line
  input wire logic sda_i,
  // Lines, 1 = released
  output logic scl_o,
  output logic sda_o,
  // Last byte plus ack bit, toggle per byte
  output logic [8:0] rx_o,
  output logic rx_tgl_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    rx_o = 9'h000;
    rx_tgl_o = 1'b0;
  end
  // One bit per 200 ns, data moved only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #50 scl_o = 1'b1;
    #50 r = sda_i;
    #50 scl_o = 1'b0;
    #50;
  endtask
  // Eight data bits then the ack bit
  task automatic byte_io(input logic [7:0] d, input logic ack);
    logic [8:0] r;
    for (int i = 8; i >= 0; i--)
      bit_io(i > 0 ? d[i - 1] : ack, r[i]);
    rx_o = r;
    rx_tgl_o = ~rx_tgl_o;
  endtask
  // Start or repeated start; offset keeps edges off the system clock
  task automatic start();
    #7 sda_o = 1'b1;
    #50 scl_o = 1'b1;
    #50 sda_o = 1'b0;
    #50 scl_o = 1'b0;
    #50;
  endtask
  // Stop; clock then stands high until the next frame
  task automatic stop();
    sda_o = 1'b0;
    #50 scl_o = 1'b1;
    #50 sda_o = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// *** verif/temp_sensor_smbus_slave_core_tb.sv ***
// Self-checking bench of the sensor core with a bus master model
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_smbus_slave_core_tb;
  localparam int unsigned CONV = 100;
  localparam int unsigned TMO = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] sel = 2'h0;
  logic [15:0] adc = 16'h0000;
  logic [1:0] ra = 2'h0;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic re_q = 1'b0;
  logic [7:0] rd;
  logic irq, oe_n, sd, scl, msda, tgl;
  logic [8:0] rx;
  logic [15:0] seed = 16'h001B;
  logic [15:0] e16;
  logic [6:0] dev;
  int w;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [17:0] q_bus[$];
  logic [17:0] q_reg[$];
  // Open-drain data line with pull-up
  wire logic sda_w = msda & (oe_n | sd);
  always #12.5 clk_i = ~clk_i;
  temp_sensor_smbus_slave_core #(.CONV_CYC(CONV), .TIMEOUT_CYC(TMO), .ID_VALUE(16'h1357)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sd), .sda_oe_n_o(oe_n),
    .addr_sel_i(sel), .adc_result_i(adc), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rd), .irq_o(irq));
  smbus_master_model i_mst (.sda_i(sda_w), .scl_o(scl), .sda_o(msda), .rx_o(rx), .rx_tgl_o(tgl));
  // --------
  // Checking
  // --------
  // Note is {expected, mask}; masked bits must match exactly
  task automatic chk(input logic [17:0] e, input logic [8:0] g);
    n_compared++;
    if ((g & e[8:0]) !== e[17:9])
    begin
      n_mismatch++;
      $display("[FAIL] %0t exp %h got %h", $time, e[17:9], g & e[8:0]);
    end
  endtask
  // Bus bytes come from the model, local reads one cycle late
  always @(tgl) if (q_bus.size() > 0) chk(q_bus.pop_front(), rx);
  always @(posedge clk_i)
  begin
    if (re_q) chk(q_reg.pop_front(), {1'b0, rd});
    re_q <= re;
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // --------
  // Drivers
  // --------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk_i);
    rst_i <= 1'b1;
    sel <= s;
    dev = 7'h48 + 7'(s);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_i);
    ra <= a;
    re <= 1'b1;
    q_reg.push_back({1'b0, e, 1'b0, m});
    @(posedge clk_i);
    re <= 1'b0;
  endtask
  task automatic wb(input logic [7:0] d, input logic nak);
    q_bus.push_back({8'h00, nak, 9'h001});
    i_mst.byte_io(d, 1'b1);
  endtask
  task automatic rb(input logic [7:0] e, input logic nak);
    q_bus.push_back({e, 1'b0, 9'h1FE});
    i_mst.byte_io(8'hFF, nak);
  endtask
  // Pointer byte first, then n data bytes high first
  task automatic wr(input logic [7:0] p, input logic nak, input int n, input logic [15:0] d);
    i_mst.start();
    wb({dev, 1'b0}, 1'b0);
    wb(p, nak);
    for (int i = n; i > 0; i--)
      wb(d[8 * i - 1 -: 8], 1'b0);
    i_mst.stop();
  endtask
  task automatic rdc(input logic [15:0] e);
    i_mst.start();
    wb({dev, 1'b1}, 1'b0);
    rb(e[15:8], 1'b0);
    rb(e[7:0], 1'b1);
    i_mst.stop();
  endtask
  task automatic rd16(input logic [7:0] p, input logic [15:0] e);
    wr(p, 1'b0, 0, 16'h0000);
    rdc(e);
  endtask
  initial
  begin
    for (int s = 2; s >= 0; s--)
    begin
      do_reset(2'(s));
      reg_rd(2'h0, 8'h00, 8'hFF);
      reg_rd(2'h1, 8'h00, 8'hFF);
      reg_rd(2'h3, 8'h00, 8'hFF);
      i_mst.start();
      wb({7'h48 + 7'((s + 1) % 3), 1'b0}, 1'b1);
      i_mst.start();
      wb({dev, 1'b0}, 1'b0);
      i_mst.stop();
    end
    seed = lfsr(seed);
    adc <= seed & 16'h3BFF;
    repeat (2 * CONV + 10) @(posedge clk_i);
    rd16(8'h00, adc & 16'hFFE0);
    rd16(8'h01, 16'h0000);
    rd16(8'h02, 16'h4000);
    rd16(8'h03, 16'h3C00);
    rd16(8'h04, 16'h0505);
    rd16(8'h07, 16'h1357);
    for (int p = 5; p < 7; p++)
      wr(8'(p), 1'b1, 0, 16'h0000);
    rdc(16'h1357);
    reg_rd(2'h0, 8'h05, 8'h05);
    wr(8'h02, 1'b0, 2, 16'h7FE0);
    rd16(8'h02, 16'h7FE0);
    wr(8'h03, 1'b0, 1, 16'h0011);
    rd16(8'h03, 16'h3C00);
    // Resolution 3: longer conversion, finer mask
    wr(8'h04, 1'b0, 1, 16'h0060);
    seed = lfsr(seed);
    adc <= seed & 16'h3BFF;
    repeat (10 * CONV) @(posedge clk_i);
    rd16(8'h00, adc & 16'hFFFC);
    wr(8'h01, 1'b0, 1, 16'h0080);
    repeat (10 * CONV) @(posedge clk_i);
    e16 = adc & 16'hFFFC;
    seed = lfsr(seed);
    adc <= seed & 16'h3BFF;
    repeat (10 * CONV) @(posedge clk_i);
    rd16(8'h00, e16);
    wr(8'h01, 1'b0, 1, 16'h0084);
    rd16(8'h00, 16'h8000);
    repeat (10 * CONV) @(posedge clk_i);
    rd16(8'h00, adc & 16'hFFFC);
    // Lockup: clock held low while the slave owns the data line
    reg_wr(2'h1, 8'h02);
    reg_rd(2'h0, 8'h00, 8'h00);
    i_mst.start();
    wb({dev, 1'b1}, 1'b0);
    for (w = 0; w < 2 * TMO && irq !== 1'b1; w++)
      @(posedge clk_i);
    if (w >= 2 * TMO)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (10) @(posedge clk_i);
    chk({8'h00, 1'b1, 9'h001}, {8'h00, oe_n});
    i_mst.stop();
    reg_wr(2'h1, 8'h00);
    reg_rd(2'h1, 8'h00, 8'hFF);
    reg_rd(2'h0, 8'h02, 8'h02);
    repeat (2) @(posedge clk_i);
    chk({8'h00, 1'b0, 9'h001}, {8'h00, irq});
    tally_and_finish();
  end
endmodule
`default_nettype wire
